// *** core/tic_consts.svh ***
`ifndef TIC_CONSTS_SVH
`define TIC_CONSTS_SVH

// ----------------------------------------------------------------------------
// Bus geometry.
// ----------------------------------------------------------------------------
`define TIC_ADR_W          12
`define TIC_DAT_W          32
`define TIC_IDX_W          10

// ----------------------------------------------------------------------------
// Register indices; the byte address is four times the index.
// ----------------------------------------------------------------------------
`define TIC_IDX_CTRL       10'h0A1
`define TIC_IDX_FRAC       10'h0A2
`define TIC_IDX_SEC        10'h0A3
`define TIC_IDX_MIN        10'h0A4
`define TIC_IDX_HOUR       10'h0A5
`define TIC_IDX_CMP        10'h0A6
`define TIC_IDX_IRQ_STAT   10'h0A7
`define TIC_IDX_IRQ_MASK   10'h0A8
`define TIC_IDX_IVL_CNT    10'h0A9

// ----------------------------------------------------------------------------
// Control register bit positions.
// ----------------------------------------------------------------------------
`define TIC_CTRL_TIME_CLOCK_ENABLE      0
`define TIC_CTRL_INTERVAL_COUNTER_ENABLE      1
`define TIC_CTRL_FLAG      2
`define TIC_CTRL_STI       3
`define TIC_CTRL_TBS_LO    4
`define TIC_CTRL_TBS_HI    5
`define TIC_CTRL_H24       6

// ----------------------------------------------------------------------------
// Interrupt status and mask bit positions.
// ----------------------------------------------------------------------------
`define TIC_IRQ_MATCH      0
`define TIC_IRQ_HOUR_WRAP  1
`define TIC_IRQ_W          2

// ----------------------------------------------------------------------------
// Counter limits and reset values.
// ----------------------------------------------------------------------------
`define TIC_FRAC_MAX       8'h7F
`define TIC_SEC_MAX        8'h3B
`define TIC_MIN_MAX        8'h3B
`define TIC_HOUR24_MAX     8'h17
`define TIC_HOURFULL_MAX   8'hFF
`define TIC_RST_BYTE       8'h00
`define TIC_ONE_BYTE       8'h01

// ----------------------------------------------------------------------------
// Timing: one fractional tick is 1/128 s.
// ----------------------------------------------------------------------------
`define TIC_TICK_PERIOD_NS 7812500
`define TIC_CLK_PERIOD_NS  10

`endif

// *** core/tic_interval_timer_unit.sv ***
`timescale 1ns/1ps
`include "tic_consts.svh"

// Functional notes
// (RL1) Counters run from the slow tick source and keep counting in power-down.
// (RL2) Software must allow time for each register access to complete.
// (RL3) Fraction counts 0..127 each 1/128 s, wrap bumps seconds.
// (RL4) Seconds count 0..59 once per second, wrap bumps minutes.
// (RL5) Minutes count 0..59 once per minute, wrap bumps hours.
// (RL6) Hours wrap after 23 with 24-hour bit set, else after 255.
// (RL7) Timebase field selects a 1/128 s, second, minute or hour update rate.
// (RL8) Eight-bit interval counter increments on selected timebase overflow.
// (RL9) Counter equal to compare value sets match flag and requests interrupt.
// (RL10) Software clears the match flag; hardware never clears it.
// (RL11) Single-shot timeout clears counter enable; otherwise counter reloads and restarts.
// (RL12) Control bit 1 enables the interval counter; clearing stops it.
// (RL13) Clearing time clock enable stops counters and restores last written values.
// (RL14) Time registers accept writes only while time clock enable is low.
// (RL15) In power-down with interrupt enabled, the match flag raises wake-up.
// (RL16) Compare register holds a written 8-bit value 0..255.
// (RL17) Control bit 7 is reserved and reads zero.
// (RL18) Interval counter clears at each timeout and when newly enabled.
module tic_interval_timer_unit
	import tic_pkg::*;
#(
	parameter int TICK_CYCLES = `TIC_TICK_PERIOD_NS / `TIC_CLK_PERIOD_NS
)(
	// Clock and reset
	input  wire logic                  CLK_SYS,
	input  wire logic                  ARST_N,
	// Wishbone slave
	input  wire logic                  WB_CYC_I,
	input  wire logic                  WB_STB_I,
	input  wire logic                  WB_WE_I,
	input  wire logic [`TIC_ADR_W-1:0] WB_ADR_I,
	input  wire logic [3:0]            WB_SEL_I,
	input  wire logic [`TIC_DAT_W-1:0] WB_DAT_I,
	output wire logic [`TIC_DAT_W-1:0] WB_DAT_O,
	output wire logic                  WB_ACK_O,
	// Core status and events
	input  wire logic                  PWR_DOWN,
	output wire logic                  IRQ,
	output wire logic                  WAKE
);

	// ------------------------------------------------------------------------
	// Declarations.
	// ------------------------------------------------------------------------
	localparam logic [31:0] TICK_LAST = 32'(TICK_CYCLES - 1);
	localparam logic [3:0][7:0] STAGE_MAX = {
		`TIC_HOURFULL_MAX, `TIC_MIN_MAX, `TIC_SEC_MAX, `TIC_FRAC_MAX
	};

	tic_wb_req_s             req;
	tic_bus_e                bus_st;
	tic_bus_e                next_bus_st;
	logic [`TIC_DAT_W-1:0]   rd_dat;
	logic [`TIC_DAT_W-1:0]   next_rd_dat;
	logic [`TIC_DAT_W-1:0]   rd_mux;
	logic [`TIC_IDX_W-1:0]   adr_idx;
	logic                    wr_fire;

	logic [31:0]             pre_cnt;
	logic [31:0]             next_pre_cnt;
	logic                    tick;

	logic [3:0][7:0]         tcnt;
	logic [3:0][7:0]         next_tcnt;
	logic [3:0][7:0]         shadow;
	logic [3:0][7:0]         next_shadow;
	logic [3:0][7:0]         stage_max;
	logic [3:0][7:0]         stage_cnt;
	logic [4:0]              carry;
	logic                    tb_ovf;

	tic_ctrl_s               ctrl;
	tic_ctrl_s               next_ctrl;
	logic [7:0]              cmp;
	logic [7:0]              next_cmp;
	logic [7:0]              ivl;
	logic [7:0]              next_ivl;
	logic [7:0]              ivl_inc;
	logic                    match;

	logic [`TIC_IRQ_W-1:0]   irq_stat;
	logic [`TIC_IRQ_W-1:0]   next_irq_stat;
	logic [`TIC_IRQ_W-1:0]   irq_mask;
	logic [`TIC_IRQ_W-1:0]   next_irq_mask;
	logic [`TIC_IRQ_W-1:0]   irq_event;

	// ------------------------------------------------------------------------
	// Bus request bundle and decode.
	// ------------------------------------------------------------------------
	assign req.cyc = WB_CYC_I;
	assign req.stb = WB_STB_I;
	assign req.we  = WB_WE_I;
	assign req.adr = WB_ADR_I;
	assign req.sel = WB_SEL_I;
	assign req.dat = WB_DAT_I;

	assign adr_idx = req.adr[`TIC_ADR_W-1:2];
	// The write lands on the same edge at which the master samples ack.
	assign wr_fire = (bus_st == TIC_BUS_ACK) && req.cyc && req.stb && req.we && req.sel[0];

	// ------------------------------------------------------------------------
	// Fractional tick prescaler.
	// ------------------------------------------------------------------------
	assign tick = ctrl.time_clock_enable && (pre_cnt == TICK_LAST); // [RL1]

	always_comb begin
		if (!ctrl.time_clock_enable || tick) begin
			next_pre_cnt = 32'h0;
		end else begin
			next_pre_cnt = pre_cnt + 32'h1;
		end
	end

	// ------------------------------------------------------------------------
	// Time counter cascade.
	// ------------------------------------------------------------------------
	assign carry[0] = tick;

	genvar g;
	for (g = 0; g < 4; g++) begin : g_stage
		if (g == 3) begin : g_hour
			assign stage_max[g] = ctrl.hour_wrap_24 ? `TIC_HOUR24_MAX : STAGE_MAX[g]; // [RL6]
		end else begin : g_low
			assign stage_max[g] = STAGE_MAX[g];
		end
		// A preset beyond the limit wraps on its next step as well.
		assign carry[g+1] = carry[g] && (tcnt[g] >= stage_max[g]); // [RL3] [RL4] [RL5]
		assign stage_cnt[g] = !carry[g] ? tcnt[g] :
			(carry[g+1] ? `TIC_RST_BYTE : tcnt[g] + `TIC_ONE_BYTE);
	end

	// ------------------------------------------------------------------------
	// Timebase selection and interval compare.
	// ------------------------------------------------------------------------
	always_comb begin
		unique case (ctrl.tbase) // [RL7]
			TIC_TB_FRAC: tb_ovf = carry[0];
			TIC_TB_SEC:  tb_ovf = carry[1];
			TIC_TB_MIN:  tb_ovf = carry[2];
			TIC_TB_HOUR: tb_ovf = carry[3];
		endcase
	end

	assign ivl_inc = ivl + `TIC_ONE_BYTE;
	assign match = ctrl.interval_counter_enable && tb_ovf && (ivl_inc == cmp); // [RL9] [RL16]

	assign irq_event[`TIC_IRQ_MATCH]     = match;
	assign irq_event[`TIC_IRQ_HOUR_WRAP] = carry[4];

	// ------------------------------------------------------------------------
	// Next state of the counters and control.
	// ------------------------------------------------------------------------
	always_comb begin
		next_tcnt     = stage_cnt;
		next_shadow   = shadow;
		next_ctrl     = ctrl;
		next_cmp      = cmp;
		next_ivl      = ivl;
		next_irq_mask = irq_mask;
		next_irq_stat = irq_stat;

		if (match) begin
			next_ivl = `TIC_RST_BYTE; // [RL18]
			if (ctrl.single_shot_select) begin
				next_ctrl.interval_counter_enable = 1'b0; // [RL11]
			end
		end else if (ctrl.interval_counter_enable && tb_ovf) begin
			next_ivl = ivl_inc; // [RL8] [RL12]
		end

		if (wr_fire) begin
			unique case (adr_idx)
				`TIC_IDX_CTRL: begin
					next_ctrl.hour_wrap_24 = req.dat[`TIC_CTRL_H24];
					next_ctrl.tbase = tic_tbase_e'(req.dat[`TIC_CTRL_TBS_HI:`TIC_CTRL_TBS_LO]);
					next_ctrl.single_shot_select = req.dat[`TIC_CTRL_STI];
					next_ctrl.interval_match_flag =
						ctrl.interval_match_flag && req.dat[`TIC_CTRL_FLAG]; // [RL10]
					next_ctrl.interval_counter_enable = req.dat[`TIC_CTRL_INTERVAL_COUNTER_ENABLE]; // [RL12]
					next_ctrl.time_clock_enable = req.dat[`TIC_CTRL_TIME_CLOCK_ENABLE];
					if (req.dat[`TIC_CTRL_INTERVAL_COUNTER_ENABLE] && !ctrl.interval_counter_enable) begin
						next_ivl = `TIC_RST_BYTE; // [RL18]
					end
					if (!req.dat[`TIC_CTRL_TIME_CLOCK_ENABLE] && ctrl.time_clock_enable) begin
						next_tcnt = shadow; // [RL13]
					end
				end
				`TIC_IDX_FRAC, `TIC_IDX_SEC, `TIC_IDX_MIN, `TIC_IDX_HOUR: begin
					if (!ctrl.time_clock_enable) begin
						next_tcnt[adr_idx[1:0] - 2'h2]   = req.dat[7:0]; // [RL14]
						next_shadow[adr_idx[1:0] - 2'h2] = req.dat[7:0]; // [RL13]
					end
				end
				`TIC_IDX_CMP: begin
					next_cmp = req.dat[7:0]; // [RL16]
				end
				`TIC_IDX_IRQ_STAT: begin
					next_irq_stat = irq_stat & ~req.dat[`TIC_IRQ_W-1:0];
				end
				`TIC_IDX_IRQ_MASK: begin
					next_irq_mask = req.dat[`TIC_IRQ_W-1:0];
				end
				default: begin
				end
			endcase
		end

		// Hardware sets win over a clear in the same cycle.
		if (match) begin
			next_ctrl.interval_match_flag = 1'b1; // [RL9]
		end
		next_irq_stat = next_irq_stat | irq_event;
	end

	// ------------------------------------------------------------------------
	// Register read multiplexer and bus handshake.
	// ------------------------------------------------------------------------
	always_comb begin
		rd_mux = '0;
		unique case (adr_idx)
			`TIC_IDX_CTRL:     rd_mux[7:0] = {1'b0, ctrl}; // [RL17]
			`TIC_IDX_FRAC:     rd_mux[7:0] = tcnt[0];
			`TIC_IDX_SEC:      rd_mux[7:0] = tcnt[1];
			`TIC_IDX_MIN:      rd_mux[7:0] = tcnt[2];
			`TIC_IDX_HOUR:     rd_mux[7:0] = tcnt[3];
			`TIC_IDX_CMP:      rd_mux[7:0] = cmp;
			`TIC_IDX_IRQ_STAT: rd_mux[`TIC_IRQ_W-1:0] = irq_stat;
			`TIC_IDX_IRQ_MASK: rd_mux[`TIC_IRQ_W-1:0] = irq_mask;
			`TIC_IDX_IVL_CNT:  rd_mux[7:0] = ivl;
			default:           rd_mux = '0;
		endcase
	end

	always_comb begin
		next_bus_st = bus_st;
		next_rd_dat = rd_dat;
		unique case (bus_st)
			TIC_BUS_IDLE: begin
				if (req.cyc && req.stb) begin
					next_bus_st = TIC_BUS_ACK;
					next_rd_dat = req.we ? '0 : rd_mux;
				end
			end
			TIC_BUS_ACK: begin
				next_bus_st = TIC_BUS_IDLE;
			end
		endcase
	end

	// ------------------------------------------------------------------------
	// Registers.
	// ------------------------------------------------------------------------
	always_ff @(posedge CLK_SYS or negedge ARST_N) begin
		if (!ARST_N) begin
			bus_st   <= TIC_BUS_IDLE;
			rd_dat   <= '0;
			pre_cnt  <= 32'h0;
			tcnt     <= '0;
			shadow   <= '0;
			ctrl     <= '0;
			cmp      <= `TIC_RST_BYTE;
			ivl      <= `TIC_RST_BYTE;
			irq_stat <= '0;
			irq_mask <= '0;
		end else begin
			bus_st   <= next_bus_st;
			rd_dat   <= next_rd_dat;
			pre_cnt  <= next_pre_cnt;
			tcnt     <= next_tcnt;
			shadow   <= next_shadow;
			ctrl     <= next_ctrl;
			cmp      <= next_cmp;
			ivl      <= next_ivl;
			irq_stat <= next_irq_stat;
			irq_mask <= next_irq_mask;
		end
	end

	// ------------------------------------------------------------------------
	// Outputs.
	// ------------------------------------------------------------------------
	assign WB_ACK_O = (bus_st == TIC_BUS_ACK);
	assign WB_DAT_O = rd_dat;
	assign IRQ      = |(irq_stat & irq_mask); // [RL9]
	assign WAKE     = PWR_DOWN && ctrl.interval_match_flag && irq_mask[`TIC_IRQ_MATCH]; // [RL15]

endmodule // tic_interval_timer_unit

// *** core/tic_pkg.sv ***
package tic_pkg;

	// ------------------------------------------------------------------------
	// Timebase choice for the interval counter.
	// ------------------------------------------------------------------------
	typedef enum logic [1:0] {
		TIC_TB_FRAC = 2'h0,
		TIC_TB_SEC  = 2'h1,
		TIC_TB_MIN  = 2'h2,
		TIC_TB_HOUR = 2'h3
	} tic_tbase_e;

	// ------------------------------------------------------------------------
	// Stored control fields, bit 6 down to bit 0.
	// ------------------------------------------------------------------------
	typedef struct packed {
		logic       hour_wrap_24;
		tic_tbase_e tbase;
		logic       single_shot_select;
		logic       interval_match_flag;
		logic       interval_counter_enable;
		logic       time_clock_enable;
	} tic_ctrl_s;

	// ------------------------------------------------------------------------
	// Bus slave states.
	// ------------------------------------------------------------------------
	typedef enum logic {
		TIC_BUS_IDLE = 1'b0,
		TIC_BUS_ACK  = 1'b1
	} tic_bus_e;

	// ------------------------------------------------------------------------
	// Wishbone request as seen by the slave.
	// ------------------------------------------------------------------------
	typedef struct packed {
		logic        cyc;
		logic        stb;
		logic        we;
		logic [11:0] adr;
		logic [3:0]  sel;
		logic [31:0] dat;
	} tic_wb_req_s;

endpackage

// *** tb/tic_interval_timer_unit_sva.sv ***
`timescale 1ns/1ps
`include "tic_consts.svh"

module tic_sva_checker
	import tic_pkg::*;
(
	// Clock and reset
	input wire logic                  CLK_SYS,
	input wire logic                  ARST_N,
	// Bus
	input wire logic                  WB_CYC_I,
	input wire logic                  WB_STB_I,
	input wire logic                  WB_WE_I,
	input wire logic [`TIC_ADR_W-1:0] WB_ADR_I,
	input wire logic [`TIC_DAT_W-1:0] WB_DAT_O,
	input wire logic                  WB_ACK_O,
	// Events
	input wire logic                  PWR_DOWN,
	input wire logic                  IRQ,
	input wire logic                  WAKE
);
	// ------------------------------------------------------------------------
	// Properties.
	// ------------------------------------------------------------------------
	default clocking @(posedge CLK_SYS); endclocking
	default disable iff (!ARST_N);

	AST_ACK_NEXT: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
		else $error("ack did not follow request");
	AST_ACK_PULSE: assert property (WB_ACK_O |=> !WB_ACK_O)
		else $error("ack longer than one cycle");
	AST_ACK_CAUSE: assert property ($rose(WB_ACK_O) |-> $past(WB_CYC_I && WB_STB_I))
		else $error("ack without request");
	AST_WAKE_PD: assert property (WAKE |-> PWR_DOWN)
		else $error("wake outside power-down");
	AST_UPPER_ZERO: assert property (WB_ACK_O |-> WB_DAT_O[31:8] == 24'h0)
		else $error("upper read bits set");
	AST_RSVD: assert property (WB_ACK_O && $past(!WB_WE_I && WB_ADR_I[11:2] == `TIC_IDX_CTRL)
		|-> !WB_DAT_O[7])
		else $error("reserved bit read as one");
	AST_FRAC: assert property (WB_ACK_O && $past(!WB_WE_I && WB_ADR_I[11:2] == `TIC_IDX_FRAC)
		|-> WB_DAT_O[7:0] <= 8'h7F)
		else $error("fraction out of range");
	AST_SEC: assert property (WB_ACK_O && $past(!WB_WE_I && WB_ADR_I[11:2] == `TIC_IDX_SEC)
		|-> WB_DAT_O[7:0] <= 8'h3B)
		else $error("seconds out of range");
	AST_MIN: assert property (WB_ACK_O && $past(!WB_WE_I && WB_ADR_I[11:2] == `TIC_IDX_MIN)
		|-> WB_DAT_O[7:0] <= 8'h3B)
		else $error("minutes out of range");
endmodule // tic_sva_checker

// *** tb/tic_interval_timer_unit_tb_top.sv ***
`timescale 1ns/1ps
`include "tic_consts.svh"

module tic_interval_timer_unit_tb_top
	import tic_pkg::*;
;
	logic                  clk, arst_n, cyc, stb, we, pd, ack, irq, wake;
	logic [`TIC_ADR_W-1:0] adr;
	logic [3:0]            sel;
	logic [`TIC_DAT_W-1:0] wdat, rdat;
	logic [7:0]            q;
	int                    n_errors, total_checks;

	tic_interval_timer_unit #(.TICK_CYCLES(4)) dut_u (.CLK_SYS(clk), .ARST_N(arst_n),
		.WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel),
		.WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack), .PWR_DOWN(pd), .IRQ(irq),
		.WAKE(wake));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// ------------------------------------------------------------------------
	// Bus access, comparison, interrupt wait, timebase scenario and closing tasks.
	// ------------------------------------------------------------------------
	task results;
		if (n_errors == 0 && total_checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask

	task chk(input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("BAD %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task acc(input logic w, input logic [9:0] i, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= {i, 2'b00};
		sel <= 4'hF;
		wdat <= {24'h000000, d};
		while (ack !== 1'b1 && n < 20) begin
			@(posedge clk);
			n++;
		end
		q = rdat[7:0];
		cyc <= 1'b0;
		stb <= 1'b0;
		if (n >= 20) begin
			n_errors++;
			$display("BAD %0t no ack", $time);
			results();
		end
	endtask

	task wr(input logic [9:0] i, input logic [7:0] d);
		acc(1'b1, i, d);
	endtask

	task rd(input logic [9:0] i, input logic [7:0] e);
		acc(1'b0, i, 8'h00);
		chk(q, e);
	endtask

	task wirq(input logic e);
		int n;
		n = 0;
		while (irq !== 1'b1 && n < 40) begin
			@(posedge clk);
			n++;
		end
		chk({7'h00, irq === 1'b1}, {7'h00, e});
	endtask

	task tbase(input logic [1:0] tb, input int dep, input logic hit);
		wr(`TIC_IDX_CTRL, 8'h00);
		wr(`TIC_IDX_FRAC, dep > 0 ? 8'h7F : 8'h00);
		wr(`TIC_IDX_SEC, dep > 1 ? 8'h3B : 8'h00);
		wr(`TIC_IDX_MIN, dep > 2 ? 8'h3B : 8'h00);
		wr(`TIC_IDX_HOUR, dep > 3 ? 8'h17 : 8'h00);
		wr(`TIC_IDX_IRQ_STAT, 8'h03);
		wr(`TIC_IDX_CTRL, 8'h4B | {2'b00, tb, 4'h0});
		wirq(hit);
		if (hit) begin
			rd(`TIC_IDX_CTRL, 8'h4D | {2'b00, tb, 4'h0});
			pd <= 1'b1;
			@(posedge clk);
			chk({7'h00, wake}, 8'h01);
			pd <= 1'b0;
		end
	endtask

	// ------------------------------------------------------------------------
	// Main sequence.
	// ------------------------------------------------------------------------
	initial begin
		arst_n = 1'b0;
		{cyc, stb, we, pd} = 4'h0;
		adr = '0;
		sel = 4'h0;
		wdat = '0;
		n_errors = 0;
		total_checks = 0;
		repeat (20) @(posedge clk);
		arst_n <= 1'b1;
		for (int i = 'hA1; i <= 'hA9; i++) rd(i[9:0], 8'h00);
		rd(10'h000, 8'h00);
		wr(`TIC_IDX_CTRL, 8'h80);
		rd(`TIC_IDX_CTRL, 8'h00);
		wr(`TIC_IDX_CMP, 8'hFF);
		rd(`TIC_IDX_CMP, 8'hFF);
		wr(`TIC_IDX_FRAC, 8'h7F);
		wr(`TIC_IDX_SEC, 8'h3B);
		wr(`TIC_IDX_MIN, 8'h3B);
		wr(`TIC_IDX_HOUR, 8'h17);
		wr(`TIC_IDX_IRQ_MASK, 8'h02);
		wr(`TIC_IDX_CTRL, 8'h41);
		wirq(1'b1);
		rd(`TIC_IDX_HOUR, 8'h00);
		rd(`TIC_IDX_MIN, 8'h00);
		rd(`TIC_IDX_SEC, 8'h00);
		wr(`TIC_IDX_SEC, 8'h05);
		rd(`TIC_IDX_SEC, 8'h00);
		rd(`TIC_IDX_IRQ_STAT, 8'h02);
		wr(`TIC_IDX_IRQ_STAT, 8'h02);
		@(posedge clk);
		chk({7'h00, irq}, 8'h00);
		wr(`TIC_IDX_CTRL, 8'h00);
		rd(`TIC_IDX_FRAC, 8'h7F);
		rd(`TIC_IDX_SEC, 8'h3B);
		rd(`TIC_IDX_MIN, 8'h3B);
		rd(`TIC_IDX_HOUR, 8'h17);
		wr(`TIC_IDX_CTRL, 8'h01);
		repeat (20) @(posedge clk);
		rd(`TIC_IDX_HOUR, 8'h18);
		wr(`TIC_IDX_CTRL, 8'h00);
		wr(`TIC_IDX_FRAC, 8'h00);
		wr(`TIC_IDX_IRQ_MASK, 8'h01);
		wr(`TIC_IDX_IRQ_STAT, 8'h03);
		wr(`TIC_IDX_CMP, 8'h02);
		wr(`TIC_IDX_CTRL, 8'h03);
		wirq(1'b1);
		rd(`TIC_IDX_CTRL, 8'h07);
		wr(`TIC_IDX_CTRL, 8'h03);
		wr(`TIC_IDX_IRQ_STAT, 8'h01);
		wirq(1'b1);
		rd(`TIC_IDX_CTRL, 8'h07);
		wr(`TIC_IDX_CMP, 8'h01);
		for (int t = 0; t < 4; t++) begin
			tbase(t < 3 ? 2'(t + 1) : 2'h3, t < 3 ? t : 2, 1'b0);
			tbase(t[1:0], t, 1'b1);
		end
		results();
	end
endmodule // tic_interval_timer_unit_tb_top

bind tic_interval_timer_unit tic_sva_checker chk_u (.CLK_SYS(CLK_SYS), .ARST_N(ARST_N),
	.WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I),
	.WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O), .PWR_DOWN(PWR_DOWN), .IRQ(IRQ), .WAKE(WAKE));
